//--- rtl/rcs_pkg.sv
package rcs_pkg;

   // register byte offsets on the apb bus
   localparam logic [11:0] RCS_OFF_CTRL   = 12'h000;
   localparam logic [11:0] RCS_OFF_PORT   = 12'h004;
   localparam logic [11:0] RCS_OFF_STATUS = 12'h008;
   localparam logic [11:0] RCS_OFF_CMD    = 12'h00c;

   // ctrl register fields
   localparam int RCS_CTRL_CLKSEL_LSB = 0;   // 2 bits: clock source
   localparam int RCS_CTRL_PINMODE_LSB = 2;  // 2 bits: port function
   localparam int RCS_CTRL_WAKE_EN_BIT = 4;
   localparam int RCS_CTRL_CD_RUN_BIT  = 5;

   // port register fields, 2 bits each
   localparam int RCS_PORT_DIR_LSB  = 0;
   localparam int RCS_PORT_OUT_LSB  = 2;
   localparam int RCS_PORT_PULL_LSB = 4;   // 1 = pull up, 0 = pull down
   localparam int RCS_PORT_PEN_LSB  = 6;   // pull enable

   // command register bits (write one to act)
   localparam int RCS_CMD_HALT_BIT = 0;
   localparam int RCS_CMD_WAIT_BIT = 1;

   localparam logic [31:0] RCS_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] RCS_PORT_RESET = 32'h0000_0000;

   // reset standby wait, counted on the main crystal
   localparam int  RCS_STANDBY_MS       = 50;
   localparam int  RCS_MAIN_CLK_MHZ     = 100;
   localparam int  RCS_STANDBY_CYCLES   = RCS_STANDBY_MS * 1000 * RCS_MAIN_CLK_MHZ;
   localparam logic [31:0] RCS_START_ADDR = 32'h0000_0000;

   typedef enum logic [1:0] {
      RCS_CLK_MAIN  = 2'b00,
      RCS_CLK_SLOW  = 2'b01,
      RCS_CLK_RC    = 2'b10
   } rcs_clksel_e;

   typedef enum logic [1:0] {
      RCS_PIN_GPIO  = 2'b00,
      RCS_PIN_XTAL  = 2'b01,
      RCS_PIN_RC    = 2'b10
   } rcs_pinmode_e;

   typedef enum logic [1:0] {
      RCS_ST_HOLD   = 2'b00,
      RCS_ST_WAIT   = 2'b01,
      RCS_ST_RUN    = 2'b10,
      RCS_ST_BACKUP = 2'b11
   } rcs_state_e;

   typedef struct packed {
      logic       valid;
      logic [1:0] dir;
      logic [1:0] dout;
      logic [1:0] pull_up;
      logic [1:0] pull_en;
   } rcs_portcfg_s;

endpackage

//--- rtl/rcs_port_pins.sv
`timescale 1ns/1ns
module rcs_port_pins
   import rcs_pkg::*;
(
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // configuration
   input  wire rcs_pkg::rcs_portcfg_s cfg,
   input  wire rcs_pkg::rcs_pinmode_e pin_mode,
   input  wire logic               osc_run,
   // pins
   input  wire logic [1:0]         pin_in,
   output logic [1:0]              pin_out,
   output logic [1:0]              pin_oe,
   output logic [1:0]              pull_up_on,
   output logic [1:0]              pull_dn_on,
   // observation
   output logic [1:0]              pin_level,
   output logic                    pin_changed
);
   logic [1:0] gpio_b;
   logic [1:0] last_reg;
   logic       osc_tog_reg;

   // bit a is the oscillator pin in either mode; bit b only for a crystal [R9]
   assign gpio_b[0] = (pin_mode == RCS_PIN_GPIO);
   assign gpio_b[1] = (pin_mode != RCS_PIN_XTAL);

   // inverting oscillator stage, stopped when halted [R8] [R12]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) osc_tog_reg <= 1'b0;
      else          osc_tog_reg <= osc_run ? ~osc_tog_reg : 1'b0;
   end

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_out[i]    <= 1'b0;
               pin_oe[i]     <= 1'b0;
               pull_up_on[i] <= 1'b0;
               pull_dn_on[i] <= 1'b0;
               last_reg[i]   <= 1'b0;
            end else begin
               pin_out[i]    <= gpio_b[i] ? cfg.dout[i] : (i == 1 ? ~osc_tog_reg : 1'b0);
               pin_oe[i]     <= gpio_b[i] ? cfg.dir[i] : (i == 1);  // [R5]
               pull_up_on[i] <= gpio_b[i] & ~cfg.dir[i] & cfg.pull_en[i] & cfg.pull_up[i];
               pull_dn_on[i] <= gpio_b[i] & ~cfg.dir[i] & cfg.pull_en[i] & ~cfg.pull_up[i]; // [R6]
               last_reg[i]   <= pin_in[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_level   <= 2'b00;
         pin_changed <= 1'b0;
      end else begin
         pin_level   <= pin_in;
         pin_changed <= |((pin_in ^ last_reg) & gpio_b);  // [R7]
      end
   end
endmodule

//--- rtl/rcs_top.sv
// Operation
// [R1] hold system reset while reset input low
// [R2] start main crystal when reset releases
// [R3] wait about 50 ms, start at zero
// [R4] cd section stays in standby at start
// [R5] each port bit has own direction
// [R6] per-bit pull up or down on inputs
// [R7] shared enable: pin change wakes backup
// [R8] port bits can drive slow crystal
// [R9] bit a alone may run rc oscillator
// [R10] reset selects main crystal clock
// [R11] software switches clock to port oscillator
// [R12] halt instruction stops port oscillator
// [R13] reset returns port bits to inputs
// [R14] software waits for oscillator to settle
// [R15] standby wait is a parameterised counter
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module rcs_top
   import rcs_pkg::*;
#(
   parameter int STANDBY_CYCLES = RCS_STANDBY_CYCLES
)(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        reset_in_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // port pins
   input  wire logic [1:0]  port_in,
   output logic [1:0]       port_out,
   output logic [1:0]       port_oe,
   output logic [1:0]       port_pull_up,
   output logic [1:0]       port_pull_dn,
   // system
   output logic             sys_reset,
   output logic             main_osc_en,
   output logic             cpu_run,
   output logic [31:0]      cpu_start_addr,
   output logic             cd_run,
   output logic [1:0]       clk_select
);
   import rcs_pkg::*;

   rcs_state_e  state_reg, state_next;
   logic [31:0] cnt_reg, cnt_next;
   logic [31:0] ctrl_reg;
   logic [31:0] port_reg;
   logic        halted_reg;
   logic [1:0]  pin_level;
   logic        pin_changed;
   logic [1:0]  pout_w, poe_w, pup_w, pdn_w;

   wire         sys_ready = (state_reg == RCS_ST_RUN) || (state_reg == RCS_ST_BACKUP);
   wire         apb_acc   = psel & penable;
   wire         apb_wr    = apb_acc & pwrite & sys_ready;
   wire         wr_ctrl   = apb_wr & (paddr == RCS_OFF_CTRL);
   wire         wr_port   = apb_wr & (paddr == RCS_OFF_PORT);
   wire         wr_cmd    = apb_wr & (paddr == RCS_OFF_CMD);
   wire         addr_ok   = (paddr == RCS_OFF_CTRL) || (paddr == RCS_OFF_PORT) ||
                            (paddr == RCS_OFF_STATUS) || (paddr == RCS_OFF_CMD);
   wire  [1:0]  f_clksel  = ctrl_reg[RCS_CTRL_CLKSEL_LSB +: 2];
   wire  [1:0]  f_pinmode = ctrl_reg[RCS_CTRL_PINMODE_LSB +: 2];
   wire         wake_en   = ctrl_reg[RCS_CTRL_WAKE_EN_BIT];
   wire         halt_cmd  = wr_cmd & pwdata[RCS_CMD_HALT_BIT];
   wire         wait_cmd  = wr_cmd & pwdata[RCS_CMD_WAIT_BIT];
   wire         wake_hit  = wake_en & pin_changed;                       // [R7]
   wire         osc_run   = (f_pinmode != RCS_PIN_GPIO) & ~halted_reg;   // [R12]
   wire  [1:0]  clk_sel_w = osc_run ? f_clksel : RCS_CLK_MAIN;           // [R11]

   function automatic logic [31:0] rd_mux(input logic [11:0] a);
      case (a)
         RCS_OFF_CTRL:   rd_mux = ctrl_reg;
         RCS_OFF_PORT:   rd_mux = port_reg;
         RCS_OFF_STATUS: rd_mux = {26'h0, pin_level, halted_reg, 1'b0, state_reg};
         default:        rd_mux = 32'h0;
      endcase
   endfunction

   rcs_portcfg_s cfg_w;
   assign cfg_w.valid   = 1'b1;
   assign cfg_w.dir     = port_reg[RCS_PORT_DIR_LSB +: 2];
   assign cfg_w.dout    = port_reg[RCS_PORT_OUT_LSB +: 2];
   assign cfg_w.pull_up = port_reg[RCS_PORT_PULL_LSB +: 2];
   assign cfg_w.pull_en = port_reg[RCS_PORT_PEN_LSB +: 2];

   // reset sequencing
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         RCS_ST_HOLD: begin
            cnt_next = 32'h0;
            if (reset_in_n) state_next = RCS_ST_WAIT;                    // [R2]
         end
         RCS_ST_WAIT: begin
            cnt_next = cnt_reg + 32'h1;                                  // [R15]
            if (cnt_reg == 32'(STANDBY_CYCLES - 1)) state_next = RCS_ST_RUN; // [R3]
         end
         RCS_ST_RUN: begin
            if (halt_cmd || wait_cmd) state_next = RCS_ST_BACKUP;
         end
         RCS_ST_BACKUP: begin
            if (wake_hit) state_next = RCS_ST_RUN;                       // [R7]
         end
      endcase
      if (!reset_in_n) state_next = RCS_ST_HOLD;                         // [R1]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= RCS_ST_HOLD;
         cnt_reg   <= 32'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // registers: system reset also clears them so the port comes back as inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg   <= RCS_CTRL_RESET;
         port_reg   <= RCS_PORT_RESET;
         halted_reg <= 1'b0;
      end else if (!sys_ready) begin
         ctrl_reg   <= RCS_CTRL_RESET;                                   // [R10]
         port_reg   <= RCS_PORT_RESET;                                   // [R13]
         halted_reg <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_reg <= {26'h0, pwdata[5:0]};
         if (wr_port) port_reg <= {24'h0, pwdata[7:0]};
         if (halt_cmd)      halted_reg <= 1'b1;                          // [R12]
         else if (wake_hit) halted_reg <= 1'b0;
      end
   end

   // apb answers in the access cycle; zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_mux(paddr) : 32'h0;
      end
   end

   rcs_port_pins u_pins (
      .pclk        (pclk),
      .presetn     (presetn),
      .cfg         (cfg_w),
      .pin_mode    (rcs_pinmode_e'(f_pinmode)),
      .osc_run     (osc_run),
      .pin_in      (port_in),
      .pin_out     (pout_w),
      .pin_oe      (poe_w),
      .pull_up_on  (pup_w),
      .pull_dn_on  (pdn_w),
      .pin_level   (pin_level),
      .pin_changed (pin_changed)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_out       <= 2'b00;
         port_oe        <= 2'b00;
         port_pull_up   <= 2'b00;
         port_pull_dn   <= 2'b00;
         sys_reset      <= 1'b1;
         main_osc_en    <= 1'b0;
         cpu_run        <= 1'b0;
         cpu_start_addr <= RCS_START_ADDR;
         cd_run         <= 1'b0;
         clk_select     <= RCS_CLK_MAIN;
      end else begin
         port_out       <= pout_w;
         port_oe        <= poe_w;
         port_pull_up   <= pup_w;
         port_pull_dn   <= pdn_w;
         sys_reset      <= (state_next == RCS_ST_HOLD);                  // [R1]
         main_osc_en    <= reset_in_n;                                   // [R2]
         cpu_run        <= (state_next == RCS_ST_RUN);                   // [R3]
         cpu_start_addr <= RCS_START_ADDR;                               // [R3]
         cd_run         <= (state_next == RCS_ST_RUN) & ctrl_reg[RCS_CTRL_CD_RUN_BIT]; // [R4]
         clk_select     <= sys_ready ? clk_sel_w : RCS_CLK_MAIN;         // [R10]
      end
   end

   // assertions
   sequence s_release;
      $rose(reset_in_n);
   endsequence

   sequence s_wait_on;
      state_reg == RCS_ST_WAIT;
   endsequence

   a_hold_reset: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      !reset_in_n |=> sys_reset && !cpu_run)
      else $error("reset input low but system not held");

   a_osc_start: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      s_release |=> main_osc_en)
      else $error("main oscillator not enabled after release");

   a_wait_start: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      (state_reg == RCS_ST_HOLD && reset_in_n) |=> s_wait_on ##0 cnt_reg == 32'h0)
      else $error("standby wait did not start at zero");

   a_wait_end: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      (s_wait_on ##0 cnt_reg == 32'(STANDBY_CYCLES - 1) ##0 reset_in_n)
      |=> state_reg == RCS_ST_RUN ##1 cpu_run)
      else $error("program did not start after standby count");

   a_cd_standby: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      $rose(cpu_run) |-> !cd_run)
      else $error("cd section running at program start");

   a_clk_reset: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      !sys_ready |=> clk_select == RCS_CLK_MAIN)
      else $error("main clock not selected in reset");

   // the cleared port register reaches the pins through two flop stages
   a_port_input: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      (!sys_ready ##1 !sys_ready ##1 !sys_ready) |=> port_oe == 2'b00)
      else $error("port not input during reset");

   a_halt_wake: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      (state_reg == RCS_ST_BACKUP && wake_hit && reset_in_n) |=> state_reg == RCS_ST_RUN)
      else $error("pin change did not release backup");

   // a stopped crystal drive must leave bit b parked, not toggling
   a_halt_stop: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
      (halted_reg && f_pinmode == RCS_PIN_XTAL)[*4] |=> $stable(port_out[1]))
      else $error("oscillator runs after halt");
endmodule

//--- verif/rcs_ext_model.sv
`timescale 1ns/1ns
module rcs_ext_model (
   // clock and bench control
   input  wire logic       pclk,
   input  wire logic       rst_hold_n,
   input  wire logic [1:0] ext_en,
   input  wire logic [1:0] ext_val,
   // device pins
   input  wire logic [1:0] port_out,
   input  wire logic [1:0] port_oe,
   input  wire logic [1:0] port_pull_up,
   input  wire logic [1:0] port_pull_dn,
   output logic [1:0]      port_in,
   output logic            reset_in_n
);
   logic [1:0] float_reg = 2'b01;

   assign reset_in_n = rst_hold_n;

   // an undriven pin never holds its last level
   always @(posedge pclk) begin
      float_reg <= ~port_in;
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (port_oe[i])
            port_in[i] = port_out[i];
         else if (ext_en[i])
            port_in[i] = ext_val[i];
         else if (port_pull_up[i])
            port_in[i] = 1'b1;
         else if (port_pull_dn[i])
            port_in[i] = 1'b0;
         else
            port_in[i] = float_reg[i];
      end
      // crystal across the pair inverts the drive of bit b into bit a
      if (port_oe[1] && !port_oe[0] && !ext_en[0])
         port_in[0] = ~port_out[1];
   end
endmodule

//--- verif/rcs_top_tb_top.sv
`timescale 1ns/1ns
module rcs_top_tb_top;
   import rcs_pkg::*;
   localparam int SB = 20;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        rst_hold_n = 0, pready, pslverr, err;
   logic        sys_reset, main_osc_en, cpu_run, cd_run, reset_in_n;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, cpu_start_addr;
   logic [1:0]  port_in, port_out, port_oe, port_pull_up, port_pull_dn;
   logic [1:0]  ext_en = 2'b11, ext_val = 2'b00, clk_select;
   int          bad_count = 0, checked = 0, n;

   always #5 pclk = ~pclk;

   rcs_top #(.STANDBY_CYCLES(SB)) u_dut (.pclk, .presetn, .reset_in_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_in, .port_out, .port_oe,
      .port_pull_up, .port_pull_dn, .sys_reset, .main_osc_en, .cpu_run, .cpu_start_addr,
      .cd_run, .clk_select);
   rcs_ext_model u_ext (.pclk, .rst_hold_n, .ext_en, .ext_val, .port_out, .port_oe,
      .port_pull_up, .port_pull_dn, .port_in, .reset_in_n);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // register change reaches the pins through two flop stages and clock select through one
   task settle;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask

   task wait_run;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (cpu_run !== 1'b1 && n < 100);
   endtask

   task test_done;
      if (bad_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (2000) @(posedge pclk);
      bad_count++;
      test_done;
   end

   initial begin
      repeat (4) @(posedge pclk);
      chk(sys_reset, 1);
      presetn <= 1;
      repeat (3) @(posedge pclk);
      chk({sys_reset, main_osc_en, cpu_run}, 3'b100);
      rst_hold_n <= 1;
      wait_run;
      chk(n >= SB && n <= SB + 4, 1);
      @(negedge pclk);
      chk({sys_reset, main_osc_en}, 2'b01);
      chk(cpu_start_addr, RCS_START_ADDR);
      chk({cd_run, clk_select, port_oe}, 0);
      apb(0, RCS_OFF_CTRL, 0);
      chk(rd, RCS_CTRL_RESET);
      apb(1, RCS_OFF_CTRL, 32'h20);
      settle;
      chk(cd_run, 1);
      apb(0, 12'h010, 0);
      chk({err, rd[0]}, 2'b10);
      apb(1, RCS_OFF_PORT, 32'h5);
      settle;
      chk({port_oe, port_out[0]}, 3'b011);
      apb(1, RCS_OFF_PORT, 32'h6);
      settle;
      chk(port_oe, 2'b10);
      ext_en <= 2'b00;
      apb(1, RCS_OFF_PORT, 32'hd0);
      settle;
      chk({port_pull_up, port_pull_dn}, 4'b0110);
      apb(0, RCS_OFF_STATUS, 0);
      chk(rd[5:4], 2'b01);
      ext_en <= 2'b11;
      apb(1, RCS_OFF_CTRL, 32'h10);
      for (int i = 0; i < 2; i++) begin
         apb(1, RCS_OFF_CMD, 32'h2);
         @(negedge pclk);
         chk(cpu_run, 0);
         @(posedge pclk);
         ext_val[i] <= ~ext_val[i];
         wait_run;
         chk(cpu_run, 1);
      end
      apb(1, RCS_OFF_CTRL, 32'h4);
      settle;
      chk(port_oe[1], 1);
      // let the new oscillator settle before switching to it
      repeat (50) @(posedge pclk);
      apb(1, RCS_OFF_CTRL, 32'h5);
      settle;
      chk(clk_select, RCS_CLK_SLOW);
      apb(1, RCS_OFF_CMD, 32'h1);
      settle;
      chk(clk_select, RCS_CLK_MAIN);
      apb(0, RCS_OFF_STATUS, 0);
      chk(rd[3], 1);
      @(posedge pclk);
      rst_hold_n <= 0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk({sys_reset, port_oe, clk_select}, 5'b10000);
      rst_hold_n <= 1;
      wait_run;
      chk(cpu_run, 1);
      apb(1, RCS_OFF_CTRL, 32'h8);
      apb(1, RCS_OFF_PORT, 32'h2);
      // settle wait before the clock switch
      repeat (50) @(posedge pclk);
      apb(1, RCS_OFF_CTRL, 32'ha);
      settle;
      chk({clk_select, port_oe}, 4'b1010);
      apb(1, RCS_OFF_CTRL, 0);
      apb(1, RCS_OFF_CMD, 32'h2);
      ext_val[0] <= ~ext_val[0];
      repeat (10) @(posedge pclk);
      chk(cpu_run, 0);
      test_done;
   end
endmodule
